// [src/seq_pkg.sv]
// constants, register map and carrier types of the dual channel power sequencer
package seq_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned US_PER_S = 1_000_000;
  localparam int unsigned NVM_CHECK_MS = 60;
  localparam int unsigned INIT_MS = 2;
  localparam int unsigned NVM_CHECK_CYC = CLK_HZ / MS_PER_S * NVM_CHECK_MS;
  localparam int unsigned INIT_CYC = CLK_HZ / MS_PER_S * INIT_MS;
  localparam int unsigned TICK_US = 1;
  localparam int unsigned TICK_CYC = CLK_HZ / US_PER_S * TICK_US;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned PRE_W = 8;
  localparam int unsigned TIME_W = 16;
  // 5 ms in microseconds
  localparam logic [TIME_W-1:0] TIME_DEFAULT_US = 16'h1388;

  // ****************************************
  // strap decoding
  // ****************************************
  localparam logic [7:0] STRAP_RESIDUAL = 8'h5A;
  localparam logic [11:0] GAIN_STEP = 12'h0C8;
  localparam logic [11:0] GAIN_ODD_BASE = 12'h064;
  localparam logic [11:0] GAIN_LOW = 12'h12C;
  localparam logic [11:0] GAIN_OPEN = 12'h1F4;
  localparam logic [11:0] GAIN_HIGH = 12'h2BC;
  localparam logic [5:0] PAIR_COLS = 6'h05;
  localparam logic [5:0] STRAP_PAIR_LAST = 6'h1D;
  localparam logic [5:0] STRAP_EQ_FIRST = 6'h1E;
  localparam logic [5:0] STRAP_EQ_LAST = 6'h23;
  localparam logic [5:0] STRAP_LOW = 6'h24;
  localparam logic [5:0] STRAP_OPEN = 6'h25;
  localparam logic [5:0] STRAP_HIGH = 6'h26;

  // ****************************************
  // register map
  // ****************************************
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_TUNE_CMD = 8'h04;
  localparam logic [ADDR_W-1:0] REG_OPERATION = 8'h08;
  localparam logic [ADDR_W-1:0] REG_TUNE_STAT = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;
  localparam logic [3:0] TSET_FIRST = 4'h2;
  localparam logic [3:0] TSET_LAST = 4'h4;
  localparam int unsigned CTRL_SRC_BIT = 0;
  localparam int unsigned CTRL_INDIV_BIT = 1;
  localparam int unsigned OP_ON_LSB = 0;
  localparam int unsigned OP_SEL_LSB = 4;
  localparam int unsigned STAT_READY_BIT = 0;
  localparam int unsigned STAT_DRV_BIT = 1;
  localparam int unsigned STAT_ST0_LSB = 4;
  localparam int unsigned STAT_ST1_LSB = 8;
  localparam int unsigned F_TON_DELAY = 0;
  localparam int unsigned F_TON_RISE = 1;
  localparam int unsigned F_TOFF_DELAY = 2;
  localparam int unsigned F_TOFF_FALL = 3;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [7:0] residual;
    logic [11:0] gain1;
    logic [11:0] gain0;
  } tuning_t;

  typedef struct packed {
    logic [TIME_W-1:0] ton_delay;
    logic [TIME_W-1:0] ton_rise;
    logic [TIME_W-1:0] toff_delay;
    logic [TIME_W-1:0] toff_fall;
  } timing_set_t;

  typedef struct packed {
    logic ramp_up;
    logic ramp_down;
    logic in_regulation;
  } ch_out_t;

  typedef enum {CH_OFF, CH_ON_WAIT, CH_RISE, CH_ON, CH_OFF_WAIT, CH_FALL} ch_state_t;

endpackage

// [src/power_sequencer.sv]
// start-up and shutdown sequencer for two output channels, with apb registers
//
// Notes on behaviour
// RULE1 - loop tuning comes from the decoded strap code or from the tuning command register.
// RULE2 - when tuning comes from the strap, the residual is forced to 90.
// RULE3 - strap codes give per-channel gain pairs, equal odd gains, or 300/500/700 for low/open/high.
// RULE4 - turn-on wait starts at an enable rising edge or an operation on command, then ramp-up.
// RULE5 - ramp-up lasts the configured turn-on ramp time, then the channel is in regulation.
// RULE6 - turn-off wait starts at an enable falling edge or an operation off command.
// RULE7 - ramp-down lasts the configured turn-off ramp time, then the channel is off.
// RULE8 - the common timing set applies to both channels unless per-channel mode is selected.
// RULE9 - after power-up a 60 ms memory check runs and any stored timing values are loaded.
// RULE10 - commands and enables are ignored until the memory check and load are done.
// RULE11 - after enable at least 2 ms of initialisation pass before any ramp-up begins.
// RULE12 - the host keeps an external sync clock stable before raising an enable pin.
// RULE13 - driver supply output follows its strap pin: floating or high on, grounded off.
// RULE14 - the host holds the enable pins low until a needed configuration is loaded.
// RULE15 - otherwise the host straps lockout to 16 V and sends the undervoltage limit last.
// RULE16 - enable edges and operation commands are equal triggers of each channel's sequencer.
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
module power_sequencer
  import seq_pkg::*;
#(
  parameter int unsigned NVM_CHECK_CYCLES = NVM_CHECK_CYC,
  parameter int unsigned INIT_CYCLES = INIT_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic channel0_enable_pin,
  input wire logic channel1_enable_pin,
  input wire logic driver_supply_enable_pin,
  input wire logic [5:0] loop_gain_strap_pin,
  // stored values from nonvolatile memory
  input wire logic nvm_valid,
  input wire timing_set_t nvm_timing,
  // outputs
  output logic driver_supply_output,
  output tuning_t loop_response_tuning,
  output ch_out_t chan_out [2],
  output logic ready
);

  // ****************************************
  // strap decoder
  // ****************************************
  function automatic tuning_t strap_decode(input logic [5:0] code);
    tuning_t t;
    logic [5:0] rel;
    t = '0;
    rel = 6'(code - STRAP_EQ_FIRST);
    t.residual = STRAP_RESIDUAL; // see RULE2
    if (code <= STRAP_PAIR_LAST) begin
      t.gain0 = 12'(GAIN_STEP * (12'(code / PAIR_COLS) + 12'h001)); // see RULE3
      t.gain1 = 12'(GAIN_STEP * (12'(code % PAIR_COLS) + 12'h001)); // see RULE3
    end else if (code <= STRAP_EQ_LAST) begin
      t.gain0 = 12'(GAIN_ODD_BASE + GAIN_STEP * 12'(rel)); // see RULE3
      t.gain1 = t.gain0;
    end else begin
      case (code)
        STRAP_LOW: t.gain0 = GAIN_LOW;
        STRAP_HIGH: t.gain0 = GAIN_HIGH;
        // unknown codes fall back to the floating-pin setting
        default: t.gain0 = GAIN_OPEN;
      endcase
      t.gain1 = t.gain0;
    end
    return t;
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] en_s1, en_s2, en_d;
  logic drv_s1, drv_s2;
  logic [5:0] strap_s1, strap_s2;
  logic [1:0] en_rise, en_fall;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      en_s1 <= '0;
      en_s2 <= '0;
      en_d <= '0;
      drv_s1 <= 1'b0;
      drv_s2 <= 1'b0;
      strap_s1 <= '0;
      strap_s2 <= '0;
    end else begin
      en_s1 <= {channel1_enable_pin, channel0_enable_pin};
      en_s2 <= en_s1;
      en_d <= en_s2;
      drv_s1 <= driver_supply_enable_pin;
      drv_s2 <= drv_s1;
      strap_s1 <= loop_gain_strap_pin;
      strap_s2 <= strap_s1;
    end
  end

  assign en_rise = en_s2 & ~en_d;
  assign en_fall = ~en_s2 & en_d;

  // the pin has an internal pull-up, so floating reads high
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      driver_supply_output <= 1'b0;
    end else begin
      driver_supply_output <= drv_s2; // see RULE13
    end
  end

  // ****************************************
  // power-on memory check
  // ****************************************
  logic [CNT_W-1:0] boot_cnt;
  logic boot_last;
  logic [TIME_W-1:0] tcfg [3][4];

  assign boot_last = (boot_cnt == CNT_W'(NVM_CHECK_CYCLES - 1));

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      boot_cnt <= '0;
      ready <= 1'b0;
    end else if (!ready) begin
      boot_cnt <= boot_cnt + 1'b1; // see RULE9
      ready <= boot_last; // see RULE10
    end
  end

  // ****************************************
  // apb slave
  // ****************************************
  logic ctrl_src, ctrl_indiv;
  tuning_t tune_cmd;
  ch_state_t st [2];
  logic setup, access, hit, ro_reg, is_tset, wr_ok, op_wr;
  logic [1:0] tset;
  logic [31:0] next_rdata;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign tset = 2'(paddr[7:4] - TSET_FIRST);
  assign is_tset = (paddr[7:4] >= TSET_FIRST) && (paddr[7:4] <= TSET_LAST);
  assign pready = 1'b1;

  always_comb begin
    hit = 1'b1;
    ro_reg = 1'b0;
    next_rdata = '0;
    if (paddr[1:0] != 2'h0) begin
      hit = 1'b0;
    end else if (is_tset) begin
      next_rdata = 32'(tcfg[tset][paddr[3:2]]);
    end else begin
      case (paddr)
        REG_CTRL: begin
          next_rdata[CTRL_SRC_BIT] = ctrl_src;
          next_rdata[CTRL_INDIV_BIT] = ctrl_indiv;
        end
        REG_TUNE_CMD: next_rdata = tune_cmd;
        REG_OPERATION: next_rdata = '0;
        REG_TUNE_STAT: begin
          next_rdata = loop_response_tuning;
          ro_reg = 1'b1;
        end
        REG_STATUS: begin
          next_rdata[STAT_READY_BIT] = ready;
          next_rdata[STAT_DRV_BIT] = driver_supply_output;
          next_rdata[STAT_ST0_LSB +: 3] = 3'(st[0]);
          next_rdata[STAT_ST1_LSB +: 3] = 3'(st[1]);
          ro_reg = 1'b1;
        end
        default: hit = 1'b0;
      endcase
    end
  end

  // writes before the memory check ends are refused with an error
  assign pslverr = access & (~hit | (pwrite & (ro_reg | ~ready))); // see RULE10
  assign wr_ok = access & pwrite & ~pslverr;
  assign op_wr = wr_ok & (paddr == REG_OPERATION);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= '0;
    end else if (setup && !pwrite) begin
      prdata <= next_rdata;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_src <= 1'b0;
      ctrl_indiv <= 1'b0;
      tune_cmd <= '0;
    end else if (wr_ok && paddr == REG_CTRL) begin
      ctrl_src <= pwdata[CTRL_SRC_BIT];
      ctrl_indiv <= pwdata[CTRL_INDIV_BIT];
    end else if (wr_ok && paddr == REG_TUNE_CMD) begin
      tune_cmd <= pwdata;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int s = 0; s < 3; s++) begin
        for (int f = 0; f < 4; f++) begin
          tcfg[s][f] <= TIME_DEFAULT_US;
        end
      end
    end else if (!ready && boot_last && nvm_valid) begin
      // stored values replace the common set only
      tcfg[0][F_TON_DELAY] <= nvm_timing.ton_delay; // see RULE9
      tcfg[0][F_TON_RISE] <= nvm_timing.ton_rise;
      tcfg[0][F_TOFF_DELAY] <= nvm_timing.toff_delay;
      tcfg[0][F_TOFF_FALL] <= nvm_timing.toff_fall;
    end else if (wr_ok && is_tset) begin
      tcfg[tset][paddr[3:2]] <= pwdata[TIME_W-1:0];
    end
  end

  // ****************************************
  // loop tuning
  // ****************************************
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      loop_response_tuning <= '0;
    end else begin
      loop_response_tuning <= ctrl_src ? tune_cmd : strap_decode(strap_s2); // see RULE1
    end
  end

  // ****************************************
  // channel sequencers
  // ****************************************
  logic [PRE_W-1:0] pre_cnt;
  logic tick;
  logic [1:0] on_req, off_req, init_ok, wait_done;
  logic [TIME_W-1:0] tcnt [2];
  logic [TIME_W-1:0] eff [2][4];
  logic [CNT_W-1:0] init_cnt [2];

  assign tick = (pre_cnt == PRE_W'(TICK_CYC - 1));

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pre_cnt <= '0;
    end else begin
      pre_cnt <= tick ? '0 : pre_cnt + 1'b1;
    end
  end

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      for (int f = 0; f < 4; f++) begin
        eff[c][f] = ctrl_indiv ? tcfg[c+1][f] : tcfg[0][f]; // see RULE8
      end
      on_req[c] = ready & (en_rise[c] | (op_wr & pwdata[OP_SEL_LSB+c] & pwdata[OP_ON_LSB+c]));
      off_req[c] = ready & (en_fall[c] | (op_wr & pwdata[OP_SEL_LSB+c] & ~pwdata[OP_ON_LSB+c]));
      init_ok[c] = init_cnt[c] >= CNT_W'(INIT_CYCLES);
      case (st[c])
        CH_ON_WAIT: wait_done[c] = tcnt[c] >= eff[c][F_TON_DELAY];
        CH_RISE: wait_done[c] = tcnt[c] >= eff[c][F_TON_RISE];
        CH_OFF_WAIT: wait_done[c] = tcnt[c] >= eff[c][F_TOFF_DELAY];
        CH_FALL: wait_done[c] = tcnt[c] >= eff[c][F_TOFF_FALL];
        default: wait_done[c] = 1'b0;
      endcase
    end
  end

  // an on command aborts a shutdown in progress and the reverse; both restart the wait
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int c = 0; c < 2; c++) begin
        st[c] <= CH_OFF;
        tcnt[c] <= '0;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        tcnt[c] <= (tick && !wait_done[c]) ? tcnt[c] + 1'b1 : tcnt[c];
        case (st[c])
          CH_OFF, CH_OFF_WAIT, CH_FALL: begin
            if (on_req[c]) begin
              st[c] <= CH_ON_WAIT; // see RULE4 see RULE16
              tcnt[c] <= '0;
            end else if (st[c] == CH_OFF_WAIT && wait_done[c]) begin
              st[c] <= CH_FALL; // see RULE6
              tcnt[c] <= '0;
            end else if (st[c] == CH_FALL && wait_done[c]) begin
              st[c] <= CH_OFF; // see RULE7
            end
          end
          CH_ON_WAIT, CH_RISE, CH_ON: begin
            if (off_req[c]) begin
              st[c] <= CH_OFF_WAIT; // see RULE6 see RULE16
              tcnt[c] <= '0;
            end else if (st[c] == CH_ON_WAIT && wait_done[c] && init_ok[c]) begin
              st[c] <= CH_RISE; // see RULE5 see RULE11
              tcnt[c] <= '0;
            end else if (st[c] == CH_RISE && wait_done[c]) begin
              st[c] <= CH_ON; // see RULE5
            end
          end
          default: st[c] <= CH_OFF;
        endcase
      end
    end
  end

  // initialisation time runs beside the turn-on wait, from the enabling trigger
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int c = 0; c < 2; c++) begin
        init_cnt[c] <= '0;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (on_req[c] && st[c] != CH_ON_WAIT && st[c] != CH_RISE && st[c] != CH_ON) begin
          init_cnt[c] <= '0; // see RULE11
        end else if (!init_ok[c]) begin
          init_cnt[c] <= init_cnt[c] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int c = 0; c < 2; c++) begin
        chan_out[c] <= '0;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        chan_out[c].ramp_up <= (st[c] == CH_RISE);
        chan_out[c].ramp_down <= (st[c] == CH_FALL);
        chan_out[c].in_regulation <= (st[c] == CH_ON) || (st[c] == CH_OFF_WAIT);
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_boot_gate_off: // see RULE10
    assert property (!ready |-> (st[0] == CH_OFF && st[1] == CH_OFF))
    else $error("channel left off before memory check finished");
  a_nvm_load: // see RULE9
    assert property (!ready && boot_last && nvm_valid |=>
      ready && tcfg[0][F_TON_RISE] == $past(nvm_timing.ton_rise))
    else $error("stored timing not loaded at end of memory check");
  a_strap_residual: // see RULE2
    assert property (!ctrl_src |=> loop_response_tuning.residual == STRAP_RESIDUAL)
    else $error("strap residual not forced");
  a_cmd_tuning: // see RULE1
    assert property (ctrl_src |=> loop_response_tuning == $past(tune_cmd))
    else $error("command tuning not applied");
  a_strap_top_gain: // see RULE3
    assert property (!ctrl_src && strap_s2 == STRAP_EQ_LAST |=>
      loop_response_tuning.gain0 == 12'h44C && loop_response_tuning.gain1 == 12'h44C)
    else $error("top equal strap gain wrong");
  a_on_trigger: // see RULE4
    assert property (ready && en_rise[0] && st[0] == CH_OFF |=> st[0] == CH_ON_WAIT)
    else $error("enable rising edge did not start turn-on wait");
  a_off_trigger: // see RULE6
    assert property (op_wr && pwdata[OP_SEL_LSB] && !pwdata[OP_ON_LSB] && st[0] == CH_ON
      |=> st[0] == CH_OFF_WAIT)
    else $error("operation off did not start turn-off wait");
  a_init_before_rise: // see RULE11
    assert property ($rose(st[0] == CH_RISE) |-> $past(init_cnt[0]) >= CNT_W'(INIT_CYCLES))
    else $error("ramp-up began before initialisation time");
  a_rise_end: // see RULE5
    assert property ($rose(st[0] == CH_ON) |-> $past(st[0]) == CH_RISE &&
      $past(tcnt[0]) >= $past(eff[0][F_TON_RISE]))
    else $error("regulation reached before ramp time");
  a_fall_end: // see RULE7
    assert property (st[0] == CH_FALL && wait_done[0] && !on_req[0] |=> st[0] == CH_OFF
      ##1 !chan_out[0].ramp_down)
    else $error("ramp-down did not end at fall time");
  a_indiv_timing: // see RULE8
    assert property (!ctrl_indiv |-> eff[1][F_TON_DELAY] == tcfg[0][F_TON_DELAY])
    else $error("common timing not shared");
  a_drv_follow: // see RULE13
    assert property (drv_s2 |=> driver_supply_output)
    else $error("driver supply not enabled by strap");

  c_ch0_on: cover property (st[0] == CH_RISE ##1 st[0] == CH_ON);
  c_ch1_off: cover property (st[1] == CH_FALL ##1 st[1] == CH_OFF);
  c_abort_off: cover property (st[0] == CH_OFF_WAIT ##1 st[0] == CH_ON_WAIT);
  c_cmd_src: cover property (ctrl_src && ctrl_indiv);

endmodule // power_sequencer

// [dv/host_model.sv]
// host-side model that drives the two channel enable pins of the sequencer
`timescale 1ns/1ps
module host_model (
  // control from the bench
  input wire logic cfg_done,
  input wire logic [1:0] en_req,
  // enable pins toward the sequencer
  output logic channel0_enable_pin,
  output logic channel1_enable_pin
);
  // pins stay low until configuration is loaded, so a half-set device never starts
  assign channel0_enable_pin = en_req[0] & cfg_done;
  assign channel1_enable_pin = en_req[1] & cfg_done;
  // no external sync clock is used here, so nothing has to settle before an enable
  // enables can always be held low, so the lockout-strap fallback is never taken
endmodule // host_model

// [dv/power_sequencer_test.sv]
// self-checking testbench of the dual channel power sequencer
`timescale 1ns/1ps
module power_sequencer_test;
  import seq_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  localparam int NVM_CYC = 50;
  localparam int INI_CYC = 20;
  localparam int US = 100;
  typedef struct {bit rd; logic err; logic [31:0] data; string name;} note_t;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  wire logic channel0_enable_pin;
  wire logic channel1_enable_pin;
  logic drv_pin = 1'b1;
  logic [5:0] strap = 6'h00;
  logic nvm_valid = 1'b1;
  timing_set_t nvm_timing = '0;
  logic driver_supply_output;
  tuning_t loop_response_tuning;
  ch_out_t chan_out [2];
  logic ready;
  logic [1:0] en_req = 2'b00;
  logic cfg_done = 1'b0;
  note_t notes [$];
  int fails = 0;
  int checked = 0;
  int cyc = 0;

  power_sequencer #(.NVM_CHECK_CYCLES(NVM_CYC), .INIT_CYCLES(INI_CYC)) power_sequencer_i (
    .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .channel0_enable_pin(channel0_enable_pin), .channel1_enable_pin(channel1_enable_pin),
    .driver_supply_enable_pin(drv_pin), .loop_gain_strap_pin(strap), .nvm_valid(nvm_valid),
    .nvm_timing(nvm_timing), .driver_supply_output(driver_supply_output),
    .loop_response_tuning(loop_response_tuning), .chan_out(chan_out), .ready(ready));
  host_model host_model_i (.cfg_done(cfg_done), .en_req(en_req),
    .channel0_enable_pin(channel0_enable_pin), .channel1_enable_pin(channel1_enable_pin));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;

  // ****************************************
  // checking
  // ****************************************
  task automatic check(input string name, input logic [32:0] exp, input logic [32:0] seen);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic in_range(input string name, input int seen, input int lo, input int hi);
    checked++;
    if (seen < lo || seen > hi) begin
      fails++;
      $display("Error %s expected %0d..%0d seen %0d", name, lo, hi, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // the oldest note belongs to the transfer now in its access edge
  always @(posedge sys_clk) begin
    note_t n;
    if (psel && penable && pready === 1'b1) begin
      if (notes.size() == 0) begin
        fails++;
        $display("Error apb transfer expected a note seen none");
      end else begin
        n = notes.pop_front();
        check(n.name, {n.err, n.rd ? n.data : 32'h0}, {pslverr, n.rd ? prdata : 32'h0});
      end
    end
  end

  // ****************************************
  // drivers
  // ****************************************
  task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] d, input logic err,
                      input logic [31:0] exp);
    notes.push_back('{!w, err, exp, $sformatf("%s %h", w ? "write" : "read", a)});
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
    xfer(1'b1, a, d, err, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
    xfer(1'b0, a, 32'h0, err, exp);
  endtask
  task automatic trig(input int c, input bit by_pin, input logic on, output int t);
    if (by_pin) begin
      @(posedge sys_clk);
      en_req[c] <= on;
    end else begin
      wr(REG_OPERATION, (32'h10 << c) | (on ? (32'h1 << c) : 32'h0), 1'b0);
    end
    t = cyc;
  endtask
  task automatic wait_out(input int c, input int idx, input logic v, output int t);
    int n;
    n = 0;
    while (chan_out[c][idx] !== v && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    t = cyc;
    if (n >= 3000) begin
      fails++;
      $display("Error channel %0d flag %0d expected %b seen timeout", c, idx, v);
    end
  endtask
  // times in microseconds; the 1 us prescaler allows one tick of slack
  task automatic run_seq(input int c, input bit by_pin, input int d, input int r, input int od,
                         input int f);
    int t0;
    int t1;
    int w;
    w = (d * US > INI_CYC) ? d * US : INI_CYC;
    trig(c, by_pin, 1'b1, t0);
    wait_out(c, 2, 1'b1, t1);
    in_range("turn-on wait", t1 - t0, (d == 0) ? INI_CYC : w - US, w + US + 8);
    wait_out(c, 0, 1'b1, t0);
    in_range("turn-on ramp", t0 - t1, r * US - US, r * US + US + 8);
    trig(c, by_pin, 1'b0, t0);
    wait_out(c, 1, 1'b1, t1);
    in_range("turn-off wait", t1 - t0, od * US - US, od * US + US + 8);
    wait_out(c, 1, 1'b0, t0);
    in_range("turn-off ramp", t0 - t1, f * US - US, f * US + US + 8);
  endtask
  function automatic logic [31:0] strap_exp(input int k);
    int g0;
    int g1;
    if (k < 30) begin
      g0 = 200 * (k / 5 + 1);
      g1 = 200 * (k % 5 + 1);
    end else begin
      case (k)
        36: g0 = 300;
        37: g0 = 500;
        38: g0 = 700;
        default: g0 = (k < 36) ? 100 + 200 * (k - 30) : 500;
      endcase
      g1 = g0;
    end
    // residual is pinned to 90 whenever the strap is the source
    return {8'h5A, g1[11:0], g0[11:0]};
  endfunction

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (40000) @(posedge sys_clk);
    fails++;
    $display("Error watchdog expected completion seen timeout");
    tally_and_finish();
  end
  initial begin
    int tv [4];
    int t0;
    int k;
    logic [31:0] tcmd;
    void'($urandom(70586));
    foreach (tv[i]) tv[i] = $urandom_range(3, 1);
    nvm_timing <= '{16'(tv[0]), 16'(tv[1]), 16'(tv[2]), 16'(tv[3])};
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    t0 = cyc;
    wr(REG_CTRL, 32'h3, 1'b1);
    wr(REG_OPERATION, 32'h13, 1'b1);
    rd(REG_STATUS, 32'h2, 1'b0);
    k = 0;
    while (ready !== 1'b1 && k < 500) begin
      @(negedge sys_clk);
      k++;
    end
    in_range("memory check time", cyc - t0, NVM_CYC - 3, NVM_CYC + 3);
    for (int i = 0; i < 4; i++) rd(8'h20 + 8'(4 * i), 32'(tv[i]), 1'b0);
    rd(8'h30, 32'h1388, 1'b0);
    for (int i = 0; i < 40; i++) begin
      k = (i == 39) ? 63 : i;
      @(posedge sys_clk);
      strap <= 6'(k);
      repeat (6) @(posedge sys_clk);
      rd(REG_TUNE_STAT, strap_exp(k), 1'b0);
      check("loop response tuning", strap_exp(k), loop_response_tuning);
    end
    tcmd = $urandom;
    wr(REG_CTRL, 32'h1, 1'b0);
    wr(REG_TUNE_CMD, tcmd, 1'b0);
    rd(REG_TUNE_STAT, tcmd, 1'b0);
    wr(REG_CTRL, 32'h0, 1'b0);
    rd(8'h14, 32'h0, 1'b1);
    rd(8'h02, 32'h0, 1'b1);
    wr(REG_STATUS, 32'hFFFF, 1'b1);
    @(posedge sys_clk);
    drv_pin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(REG_STATUS, 32'h1, 1'b0);
    check("driver supply output", 33'h0, {32'h0, driver_supply_output});
    drv_pin <= 1'b1;
    cfg_done <= 1'b1;
    // stored values drive the first pin-started sequence
    run_seq(0, 1'b1, tv[0], tv[1], tv[2], tv[3]);
    for (int i = 0; i < 4; i++) wr(8'h20 + 8'(4 * i), 32'(i % 2 + 2 - i / 2), 1'b0);
    run_seq(1, 1'b0, 2, 3, 1, 2);
    wr(REG_CTRL, 32'h2, 1'b0);
    for (int i = 0; i < 4; i++) wr(8'h40 + 8'(4 * i), 32'(4 - i % 2 * 3 - i / 2), 1'b0);
    for (int i = 0; i < 4; i++) wr(8'h30 + 8'(4 * i), (i == 0) ? 32'h0 : 32'h1, 1'b0);
    run_seq(1, 1'b1, 4, 1, 3, 0);
    run_seq(0, 1'b0, 0, 1, 1, 1);
    // second power-up with nothing stored: the common set must keep its 5 ms default
    @(posedge sys_clk);
    nvm_valid <= 1'b0;
    nrst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    while (ready !== 1'b1) @(posedge sys_clk);
    rd(8'h20, 32'h1388, 1'b0);
    tally_and_finish();
  end
endmodule // power_sequencer_test
